// ### abpo_change_det.sv
// Registers a group of pin levels and flags any change.
`timescale 1ns/100ps
`default_nettype none
module abpo_change_det #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Level in and registered level out.
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout,
	output logic              changed
);
	logic [W-1:0] next_dout;
	logic         next_changed;

	always_comb begin
		next_dout    = din;
		next_changed = (din != dout);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout    <= '0;
			changed <= 1'b0;
		end else begin
			dout    <= next_dout;
			changed <= next_changed;
		end
	end

	AST_CHANGE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		(din != dout) |=> changed && dout == $past(din))
		else $error("change detector missed a change");
endmodule : abpo_change_det
`default_nettype wire

// ### abpo_consts.svh
// Register offsets, field positions and reset values of the pin option block.
// Contract
// - Bit 7 set turns three pins into buttons reported on endpoint bits 2:0.
// - Bit 6 set searches the drive bus once after reset; cleared means none.
// - Bit 5 selects pinout: 0 is 56-pin, 1 is 100-pin.
// - In suspend, bit 4 clear keeps drive pins driven; set floats them.
// - Bit 1 sets power-valid polarity: 0 active low, 1 active high.
// - Bit 0 enables power-valid input and removable drive as bus master.
`ifndef ABPO_CONSTS_SVH
`define ABPO_CONSTS_SVH

`define ABPO_OFS_IRQ_STATUS 8'h00
`define ABPO_OFS_IRQ_MASK   8'h04
`define ABPO_OFS_PIN_OPTION 8'h08
`define ABPO_OFS_CONTROL    8'h0C
`define ABPO_OFS_STATE      8'h10

`define ABPO_PIN_OPTION_RST 8'h78

`define ABPO_BIT_BUTTON   7
`define ABPO_BIT_SCAN     6
`define ABPO_BIT_PINOUT   5
`define ABPO_BIT_FLOAT    4
`define ABPO_BIT_RSVD_HI  3
`define ABPO_BIT_RSVD_LO  2
`define ABPO_BIT_POL      1
`define ABPO_BIT_PV_EN    0

`define ABPO_CTRL_LOAD    0

`define ABPO_IRQ_LOADED   0
`define ABPO_IRQ_BUTTON   1
`define ABPO_IRQ_POWER    2
`define ABPO_IRQ_BADCFG   3
`define ABPO_IRQ_W        4

`endif

// ### abpo_pin_option.sv
// APB register bank that latches and applies the pin option byte.
`timescale 1ns/100ps
`default_nettype none
`include "abpo_consts.svh"
module abpo_pin_option #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [31:0]       prdata,
	// Interrupt.
	output logic                   irq,
	// Multi-use pins, three signals each except the input-only drive power valid pin.
	input  wire logic              pullup_enable_pin_in,
	output logic                   pullup_enable_pin_out,
	output logic                   pullup_enable_pin_oe_n,
	input  wire logic              high_power_indicator_n_in,
	output logic                   high_power_indicator_n_out,
	output logic                   high_power_indicator_n_oe_n,
	input  wire logic              drive_power_valid_pin,
	// Values driven on the multi-use pins outside button mode.
	input  wire logic              pullup_enable_req,
	input  wire logic              high_power_req,
	// USB suspend and drive bus control.
	input  wire logic              suspend_in,
	output logic                   ata_pin_oe_n,
	// Decoded settings.
	output logic                   cfg_loaded,
	output logic      [2:0]        first_interrupt_in_endpoint,
	output logic                   fixed_drive_scan_start,
	output logic                   large_pinout_select,
	output logic                   suspend_float_select,
	output logic                   removable_enable,
	output logic                   drive_power_ok
);
	abpo_pkg::abpo_state_t state;
	abpo_pkg::abpo_state_t next_state;

	logic [7:0]                   pin_option_config;
	logic [7:0]                   next_pin_option_config;
	logic [7:0]                   pin_option_active;
	logic [7:0]                   next_pin_option_active;
	logic [`ABPO_IRQ_W-1:0]       irq_status;
	logic [`ABPO_IRQ_W-1:0]       next_irq_status;
	logic [`ABPO_IRQ_W-1:0]       irq_mask;
	logic [`ABPO_IRQ_W-1:0]       next_irq_mask;
	logic [31:0]                  next_prdata;
	logic                         next_scan;
	logic                         next_power_ok;
	logic                         power_ok_q;

	logic                         wr_en;
	logic                         rd_setup;
	logic                         mapped;
	logic                         load_req;
	logic                         button_mode;
	logic                         pv_enabled;
	logic [2:0]                   btn_raw;
	logic [2:0]                   btn_q;
	logic                         btn_changed;
	logic                         pv_level;
	logic                         pv_q;
	logic                         pv_changed;
	logic [`ABPO_IRQ_W-1:0]       events;

	// Zero wait states: the write lands at the access edge, read data is captured at setup.
	assign pready   = 1'b1;
	assign wr_en    = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign pslverr  = psel && penable && !mapped;

	always_comb begin
		case (paddr)
			`ABPO_OFS_IRQ_STATUS,
			`ABPO_OFS_IRQ_MASK,
			`ABPO_OFS_PIN_OPTION,
			`ABPO_OFS_CONTROL,
			`ABPO_OFS_STATE: mapped = 1'b1;
			default:         mapped = 1'b0;
		endcase
	end

	assign load_req = wr_en && paddr == `ABPO_OFS_CONTROL && pwdata[`ABPO_CTRL_LOAD];

	// Only the latched copy steers the pins, so later writes cannot disturb a running drive.
	assign button_mode = cfg_loaded && pin_option_active[`ABPO_BIT_BUTTON];
	assign pv_enabled  = cfg_loaded && pin_option_active[`ABPO_BIT_PV_EN]
		&& !pin_option_active[`ABPO_BIT_BUTTON];

	assign btn_raw  = button_mode ?
		{pullup_enable_pin_in, high_power_indicator_n_in, drive_power_valid_pin} : 3'h0;
	assign pv_level = pin_option_active[`ABPO_BIT_POL] ?
		drive_power_valid_pin : !drive_power_valid_pin;

	abpo_change_det #(
		.W (3)
	) u_btn_det (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (btn_raw),
		.dout    (btn_q),
		.changed (btn_changed)
	);

	abpo_change_det #(
		.W (1)
	) u_pv_det (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (pv_level && pv_enabled),
		.dout    (pv_q),
		.changed (pv_changed)
	);

	// Pins turn to inputs in button mode.
	assign pullup_enable_pin_out       = pullup_enable_req;
	assign high_power_indicator_n_out  = !high_power_req;
	assign pullup_enable_pin_oe_n      = button_mode;
	assign high_power_indicator_n_oe_n = button_mode;

	assign ata_pin_oe_n         = suspend_in && pin_option_active[`ABPO_BIT_FLOAT];
	assign suspend_float_select = pin_option_active[`ABPO_BIT_FLOAT];
	assign large_pinout_select  = pin_option_active[`ABPO_BIT_PINOUT];
	assign removable_enable     = cfg_loaded && pin_option_active[`ABPO_BIT_PV_EN];
	assign first_interrupt_in_endpoint = btn_q;
	assign drive_power_ok       = power_ok_q;
	assign cfg_loaded           = (state == abpo_pkg::ABPO_LOADED);
	assign irq                  = |(irq_status & irq_mask);

	always_comb begin
		events                   = '0;
		events[`ABPO_IRQ_BUTTON] = btn_changed;
		events[`ABPO_IRQ_POWER]  = pv_changed;
		if (state == abpo_pkg::ABPO_WAIT_LOAD && load_req) begin
			events[`ABPO_IRQ_LOADED] = 1'b1;
			events[`ABPO_IRQ_BADCFG] = pin_option_config[`ABPO_BIT_RSVD_HI]
				|| pin_option_config[`ABPO_BIT_RSVD_LO]
				|| (pin_option_config[`ABPO_BIT_BUTTON]
				&& !pin_option_config[`ABPO_BIT_PINOUT]);
		end
	end

	always_comb begin
		next_state             = state;
		next_pin_option_config = pin_option_config;
		next_pin_option_active = pin_option_active;
		next_irq_mask          = irq_mask;
		next_irq_status        = irq_status;
		next_scan              = 1'b0;
		next_power_ok          = pv_q;
		next_prdata            = prdata;
		if (wr_en && paddr == `ABPO_OFS_PIN_OPTION) begin
			next_pin_option_config = pwdata[7:0];
		end
		if (wr_en && paddr == `ABPO_OFS_IRQ_MASK) begin
			next_irq_mask = pwdata[`ABPO_IRQ_W-1:0];
		end
		if (wr_en && paddr == `ABPO_OFS_IRQ_STATUS) begin
			next_irq_status = irq_status & ~pwdata[`ABPO_IRQ_W-1:0];
		end
		// A new event wins over a clear written in the same cycle.
		next_irq_status = next_irq_status | events;
		case (state)
			abpo_pkg::ABPO_WAIT_LOAD: begin
				if (load_req) begin
					next_state             = abpo_pkg::ABPO_LOADED;
					next_pin_option_active = pin_option_config;
					next_scan              = pin_option_config[`ABPO_BIT_SCAN];
				end
			end
			abpo_pkg::ABPO_LOADED: begin
				next_state = abpo_pkg::ABPO_LOADED;
			end
			default: begin
				next_state = abpo_pkg::ABPO_WAIT_LOAD;
			end
		endcase
		if (rd_setup) begin
			case (paddr)
				`ABPO_OFS_IRQ_STATUS: next_prdata = {28'h0000000, irq_status};
				`ABPO_OFS_IRQ_MASK:   next_prdata = {28'h0000000, irq_mask};
				`ABPO_OFS_PIN_OPTION: next_prdata = {24'h000000, pin_option_config};
				`ABPO_OFS_STATE:      next_prdata = {16'h0000, pin_option_active,
					3'h0, power_ok_q, btn_q, cfg_loaded};
				default:              next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                  <= abpo_pkg::ABPO_WAIT_LOAD;
			pin_option_config      <= `ABPO_PIN_OPTION_RST;
			pin_option_active      <= `ABPO_PIN_OPTION_RST;
			irq_status             <= '0;
			irq_mask               <= '0;
			fixed_drive_scan_start <= 1'b0;
			power_ok_q             <= 1'b0;
			prdata                 <= 32'h00000000;
		end else begin
			state                  <= next_state;
			pin_option_config      <= next_pin_option_config;
			pin_option_active      <= next_pin_option_active;
			irq_status             <= next_irq_status;
			irq_mask               <= next_irq_mask;
			fixed_drive_scan_start <= next_scan;
			power_ok_q             <= next_power_ok;
			prdata                 <= next_prdata;
		end
	end

	sequence s_load;
		state == abpo_pkg::ABPO_WAIT_LOAD && load_req;
	endsequence

	sequence s_latched;
		cfg_loaded && pin_option_active == $past(pin_option_config);
	endsequence

	AST_LOAD_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
		s_load |=> s_latched)
		else $error("configuration byte not latched on load");

	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_loaded && $past(cfg_loaded) |-> $stable(pin_option_active))
		else $error("latched configuration changed after load");

	AST_SCAN_ON_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		s_load |=> fixed_drive_scan_start == pin_option_active[`ABPO_BIT_SCAN]
		##1 !fixed_drive_scan_start)
		else $error("bus search pulse wrong after load");

	AST_SCAN_ONLY_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
		fixed_drive_scan_start |-> $rose(cfg_loaded) && pin_option_active[`ABPO_BIT_SCAN])
		else $error("bus search without a set search bit at load");

	AST_PINOUT: assert property (@(posedge pclk) disable iff (!presetn)
		s_load |=> large_pinout_select == $past(pin_option_config[`ABPO_BIT_PINOUT]))
		else $error("pinout select does not follow bit 5");

	AST_SUSPEND_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
		(!suspend_in || !pin_option_active[`ABPO_BIT_FLOAT]) |-> !ata_pin_oe_n)
		else $error("drive pins released while they must be driven");

	AST_BUTTON_REPORT: assert property (@(posedge pclk) disable iff (!presetn)
		button_mode && $past(button_mode) |->
		first_interrupt_in_endpoint == {$past(pullup_enable_pin_in),
		$past(high_power_indicator_n_in), $past(drive_power_valid_pin)}
		&& pullup_enable_pin_oe_n && high_power_indicator_n_oe_n)
		else $error("button pins not reported on endpoint bits");

	AST_POL_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		pv_enabled && pin_option_active[`ABPO_BIT_POL] && drive_power_valid_pin
		|=> ##1 drive_power_ok)
		else $error("active high power valid not seen");

	AST_POL_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		pv_enabled && !pin_option_active[`ABPO_BIT_POL] && !drive_power_valid_pin
		|=> ##1 drive_power_ok)
		else $error("active low power valid not seen");

	AST_PV_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
		!pv_enabled [*2] |=> !drive_power_ok && (removable_enable == pv_enabled
		|| pin_option_active[`ABPO_BIT_BUTTON]))
		else $error("power valid reported while removable support is off");

	// Those down to AST_POL_INACTIVE watch the latched copy, since a later write to the byte must not move the pins.
	AST_SUSPEND_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
		suspend_in && pin_option_active[`ABPO_BIT_FLOAT]
		|-> ata_pin_oe_n)
		else $error("drive pins driven while they must float");

	AST_BUTTON_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!button_mode |-> !pullup_enable_pin_oe_n && !high_power_indicator_n_oe_n
		##1 first_interrupt_in_endpoint == 3'h0)
		else $error("button report or pin release outside button mode");

	AST_BUTTON_NO_POWER: assert property (@(posedge pclk) disable iff (!presetn)
		button_mode
		|=> ##1 !drive_power_ok)
		else $error("power valid used while its pin is a button");

	AST_POL_INACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
		pv_enabled && pin_option_active[`ABPO_BIT_POL] != drive_power_valid_pin
		|=> ##1 !drive_power_ok)
		else $error("inactive power valid level reported as valid");

	AST_LOAD_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		s_load
		|=> irq_status[`ABPO_IRQ_LOADED])
		else $error("load not recorded in the status register");

	AST_NO_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_loaded
		|=> cfg_loaded && !fixed_drive_scan_start)
		else $error("configuration loaded a second time");
endmodule : abpo_pin_option
`default_nettype wire

// ### abpo_pin_partner.sv
// Model of the buttons and the drive power pin at the far side of the block.
`timescale 1ns/100ps
`default_nettype none
module abpo_pin_partner (
	// Levels that the far side presents.
	input  wire logic [2:0] lv,
	// Pin drivers of the block.
	input  wire logic       pu_out,
	input  wire logic       pu_oe_n,
	input  wire logic       hp_out,
	input  wire logic       hp_oe_n,
	// Resolved pin levels.
	output logic            pu_wire,
	output logic            hp_wire,
	output logic            pv_pin
);
	// A released pin shows the button level, so a stale driver value cannot pass.
	assign pu_wire = pu_oe_n ? lv[2] : pu_out;
	assign hp_wire = hp_oe_n ? lv[1] : hp_out;
	assign pv_pin  = lv[0];
endmodule : abpo_pin_partner
`default_nettype wire

// ### abpo_pkg.sv
// Types shared by the pin option block.
package abpo_pkg;
	typedef enum logic [0:0] {
		ABPO_WAIT_LOAD,
		ABPO_LOADED
	} abpo_state_t;
endpackage : abpo_pkg

// ### ata_bridge_pin_option_config_tb.sv
// Self-checking bench of the pin option register bank.
`timescale 1ns/100ps
`default_nettype none
module ata_bridge_pin_option_config_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        pu_req = 1'b0;
	logic        hp_req = 1'b0;
	logic        susp = 1'b0;
	logic [2:0]  lv = 3'h0;
	logic        pready, pslverr, irq, pu_out, pu_oe_n, hp_out, hp_oe_n, pu_wire, hp_wire;
	logic        pv_pin, loaded, scan, big, flt, rem_en, pw_ok, ata_oe_n, err;
	logic [2:0]  ep;
	logic [31:0] prdata, rd;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          scan_cnt = 0;
	// Each row holds the configuration byte and the loaded and bad-setting status it gives.
	logic [11:0] rows [5] = '{12'hA31, 12'h531, 12'h411, 12'h201, 12'h849};
	always #20 pclk = ~pclk;
	abpo_pin_option u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .irq(irq), .pullup_enable_pin_in(pu_wire),
		.pullup_enable_pin_out(pu_out), .pullup_enable_pin_oe_n(pu_oe_n),
		.high_power_indicator_n_in(hp_wire), .high_power_indicator_n_out(hp_out),
		.high_power_indicator_n_oe_n(hp_oe_n), .drive_power_valid_pin(pv_pin),
		.pullup_enable_req(pu_req), .high_power_req(hp_req), .suspend_in(susp),
		.ata_pin_oe_n(ata_oe_n), .cfg_loaded(loaded), .first_interrupt_in_endpoint(ep),
		.fixed_drive_scan_start(scan), .large_pinout_select(big),
		.suspend_float_select(flt), .removable_enable(rem_en), .drive_power_ok(pw_ok));
	abpo_pin_partner u_far (.lv(lv), .pu_out(pu_out), .pu_oe_n(pu_oe_n), .hp_out(hp_out),
		.hp_oe_n(hp_oe_n), .pu_wire(pu_wire), .hp_wire(hp_wire), .pv_pin(pv_pin));
	task automatic complete_run;
		if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk
	// The master waits for pready with no assumed latency; the cycle ceiling ends a hang.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick
	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset
	always @(posedge pclk) begin
		cyc++;
		if (scan === 1'b1) scan_cnt++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		logic [7:0] c;
		do_reset();
		tick(1);
		chk({big, flt, rem_en, loaded}, 4'hC);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h78);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0000_7800);
		apb(1'b0, 8'h14, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		susp <= 1'b1;
		tick(1);
		chk(ata_oe_n, 1'b1);
		for (int i = 0; i < 5; i++) begin
			c = rows[i][11:4];
			do_reset();
			scan_cnt = 0;
			chk({big, flt, loaded, ep, pw_ok, irq}, 8'hC0);
			apb(1'b1, 8'h08, {24'h0, c});
			apb(1'b1, 8'h0C, 32'h1);
			tick(2);
			chk(scan_cnt, c[6]);
			chk({loaded, big, flt, rem_en, pu_oe_n, hp_oe_n}, {1'b1, c[5:4], c[0], c[7], c[7]});
			apb(1'b0, 8'h00, 32'h0);
			chk(rd & 32'h9, rows[i][3:0]);
			tick(1);
			chk(ata_oe_n, c[4]);
			@(posedge pclk);
			susp <= 1'b0;
			tick(1);
			chk(ata_oe_n, 1'b0);
			@(posedge pclk);
			susp <= 1'b1;
			for (int k = 0; k < 2; k++) begin
				@(posedge pclk);
				lv <= (k == 1) ? 3'h5 : 3'h2;
				pu_req <= (k == 0);
				hp_req <= (k == 0);
				tick(3);
				chk(ep, c[7] ? ((k == 1) ? 3'h5 : 3'h2) : 3'h0);
				chk({pu_out, hp_out}, (k == 0) ? 2'h2 : 2'h1);
				chk(pw_ok, c[0] & !c[7] & (k == c[1]));
			end
		end
		apb(1'b1, 8'h08, 32'h20);
		apb(1'b1, 8'h0C, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd[15:8], 8'h84);
		apb(1'b0, 8'h08, 32'h0);
		chk(big, 1'b0);
		chk(rd, 32'h20);
		chk(irq, 1'b0);
		apb(1'b1, 8'h04, 32'h1);
		tick(1);
		chk(irq, 1'b1);
		apb(1'b1, 8'h00, 32'h1);
		tick(1);
		chk(irq, 1'b0);
		complete_run();
	end
endmodule : ata_bridge_pin_option_config_tb
`default_nettype wire
